/* core/gage_lock_consts.svh */
`ifndef GAGE_LOCK_CONSTS_SVH
`define GAGE_LOCK_CONSTS_SVH

// ==========================================================
// shared-memory backplane word map (word addresses)
`define BP_ADDR_W 10
`define HSK_WORD 10'h000
`define FLAGS_A_WORD 10'h01E
`define FLAGS_B_WORD 10'h01F
`define CMD_FIRST_WORD 10'h002
`define CMD_LAST_WORD 10'h009

// ==========================================================
// handshake word fields
`define HSK_LOCK_BIT 0
`define HSK_BUSY_BIT 2
`define HSK_RESET 16'h0000

// ==========================================================
// result image layout
`define NUM_GAGES 12
`define GAGES_PER_BYTE 4
`define FLAGS_A_LSB 8
`define IMG_RESET 16'h0000
`define CMD_BITS 128
`define CMD_WORD_W 16
`define CMD_IDX_W 3

// ==========================================================
// port numbering of the same images, kept for reference
`define RIO_WORD_A 6
`define RIO_WORD_B 7
`define RIO_UPPER_LSB 8
`define HEX_BYTE_A 31
`define HEX_BYTE_B 32
`define HEX_BYTE_C 33
`define SER_BYTE_A 36
`define SER_BYTE_B_LO 39
`define SER_BYTE_B_HI 38

`endif

/* core/gage_lock_pkg.sv */
`include "gage_lock_consts.svh"

package gage_lock_pkg;

   // ==========================================================
   // carriers
   // index 0 is gage 53, index 11 is gage 64; 1 = fail
   typedef struct packed {
      logic [`NUM_GAGES-1:0] fault;
      logic [`NUM_GAGES-1:0] warn;
   } gage_flags_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [`BP_ADDR_W-1:0] addr;
      logic [15:0] wdata;
   } bp_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] rdata;
   } bp_rsp_t;

   typedef struct packed {
      logic [15:0] word_a;
      logic [15:0] word_b;
   } rio_image_t;

   typedef struct packed {
      logic [7:0] byte_a;
      logic [7:0] byte_b;
      logic [7:0] byte_c;
   } hex_image_t;

   typedef struct packed {
      logic [7:0] byte_a;
      logic [7:0] byte_b_hi;
      logic [7:0] byte_b_lo;
   } ser_image_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WR_A = 2'b01,
      ST_WR_B = 2'b10,
      ST_DONE = 2'b11
   } post_state_t;

endpackage

/* core/gage_flags_and_data_lock.sv */
`timescale 1ns/1ps
`include "gage_lock_consts.svh"
// Summary of operation
// - each gage reports a warning and a fault flag, 0 for pass, 1 for fail.
// - backplane word 30 bits 8-15 hold gages 53-56, word 31 gages 57-64.
// - remote I/O shows the flags in words 6 and 7, upper byte octal 10-17.
// - hex serial bytes 31, 32, 33 carry gages 53, 57, 61 in groups of four.
// - byte serial swaps bytes: word 30 high to 36, 31 low to 39, high to 38.
// - the data-lock handshake word exists on the backplane only.
// - while host lock bit 0 of word 0 is 1 the module writes no backplane results.
// - the module holds bit 2 of word 0 high for the whole results write.
// - the command bits are reachable from backplane and remote I/O alike.
// - remote I/O bit numbers are octal, everything else decimal.
// - backplane posts at completion, other ports only at program end.

module gage_flags_and_data_lock (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   input wire gage_lock_pkg::bp_req_t bp_req,
   output gage_lock_pkg::bp_rsp_t bp_rsp,
   input wire logic result_valid,
   input wire gage_lock_pkg::gage_flags_t result_flags,
   input wire logic prog_end,
   input wire logic rio_cmd_we,
   input wire logic [`CMD_IDX_W-1:0] rio_cmd_idx,
   input wire logic [`CMD_WORD_W-1:0] rio_cmd_data,
   output gage_lock_pkg::rio_image_t rio_img,
   output gage_lock_pkg::hex_image_t hex_img,
   output gage_lock_pkg::ser_image_t ser_img,
   output logic [`CMD_BITS-1:0] cmd_bits,
   output logic host_lock,
   output logic dev_busy
);
   import gage_lock_pkg::*;

   // ==========================================================
   // flag packing
   // warning on the even bit, fault on the odd bit above it
   function automatic logic [7:0] pack_group(input gage_flags_t g,
                                             input int grp);
      logic [3:0] w;
      logic [3:0] f;
      w = g.warn[grp*`GAGES_PER_BYTE +: `GAGES_PER_BYTE];
      f = g.fault[grp*`GAGES_PER_BYTE +: `GAGES_PER_BYTE];
      pack_group = {f[3], w[3], f[2], w[2], f[1], w[1], f[0], w[0]};
   endfunction

   // ==========================================================
   // state
   post_state_t state_r;
   post_state_t state_nxt;
   gage_flags_t latest_r;
   gage_flags_t stage_r;
   logic pend_r;
   logic pend_nxt;
   logic lock_r;
   logic busy_r;
   logic busy_nxt;
   logic [7:0] img_a_r;
   logic [15:0] img_b_r;
   logic [`CMD_BITS-1:0] cmd_r;
   bp_rsp_t rsp_r;
   rio_image_t rio_r;
   hex_image_t hex_r;
   ser_image_t ser_r;

   // ==========================================================
   // backplane address decode
   wire hit_hsk = bp_req.addr == `HSK_WORD;
   wire hit_a = bp_req.addr == `FLAGS_A_WORD;
   wire hit_b = bp_req.addr == `FLAGS_B_WORD;
   wire hit_cmd = (bp_req.addr >= `CMD_FIRST_WORD) &&
                  (bp_req.addr <= `CMD_LAST_WORD);
   wire [`BP_ADDR_W-1:0] cmd_off = bp_req.addr - `CMD_FIRST_WORD;
   wire [`CMD_IDX_W-1:0] bp_cmd_idx = cmd_off[`CMD_IDX_W-1:0];
   wire [6:0] bp_cmd_lsb = {bp_cmd_idx, 4'h0};
   wire [6:0] rio_cmd_lsb = {rio_cmd_idx, 4'h0};

   // reserved bits of the handshake word read back as zero
   wire [15:0] hsk_word = {13'h0000, busy_r, 1'b0, lock_r};
   wire [15:0] img_a_word = {img_a_r, 8'h00};
   wire [15:0] cmd_word = cmd_r[bp_cmd_lsb +: `CMD_WORD_W];

   // the handshake word answers only on this port
   wire [15:0] rd_word = hit_hsk ? hsk_word :
                         hit_a ? img_a_word :
                         hit_b ? img_b_r :
                         hit_cmd ? cmd_word :
                         16'h0000;

   wire wr_hsk = bp_req.wr && hit_hsk;
   wire wr_cmd_bp = bp_req.wr && hit_cmd;

   // ==========================================================
   // result posting sequence
   // a result that lands mid-post waits in latest_r, so the two
   // image words always belong to the same inspection
   wire gage_flags_t newest = result_valid ? result_flags : latest_r;
   wire want_post = pend_r || result_valid;
   wire start_post = (state_r == ST_IDLE || state_r == ST_DONE) &&
                     want_post && !lock_r;
   wire step_ok = !lock_r;

   wire [7:0] grp_a = pack_group(stage_r, 0);
   wire [7:0] grp_b = pack_group(stage_r, 1);
   wire [7:0] grp_c = pack_group(stage_r, 2);

   // other ports take the newest result, not the staged one
   wire [7:0] out_a = pack_group(newest, 0);
   wire [7:0] out_b = pack_group(newest, 1);
   wire [7:0] out_c = pack_group(newest, 2);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_post) begin
               state_nxt = ST_WR_A;
            end
         end
         ST_WR_A: begin
            if (step_ok) begin
               state_nxt = ST_WR_B;
            end
         end
         ST_WR_B: begin
            if (step_ok) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            if (start_post) begin
               state_nxt = ST_WR_A;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // busy spans every cycle in which an image word may change
   assign busy_nxt = (state_nxt == ST_WR_A) || (state_nxt == ST_WR_B);
   // a new result arriving as the post starts stays pending
   assign pend_nxt = result_valid || (pend_r && !start_post);

   // ==========================================================
   // sequencer and handshake registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= ST_IDLE;
         pend_r <= 1'b0;
         busy_r <= 1'b0;
         lock_r <= 1'b0;
         latest_r <= '0;
         stage_r <= '0;
      end else if (ce) begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
         busy_r <= busy_nxt;
         if (result_valid) begin
            latest_r <= result_flags;
         end
         if (start_post) begin
            stage_r <= newest;
         end
         if (wr_hsk) begin
            // only the lock bit is writable
            lock_r <= bp_req.wdata[`HSK_LOCK_BIT];
         end
      end
   end

   // ==========================================================
   // backplane result image, posted as soon as it is ready
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         img_a_r <= 8'h00;
         img_b_r <= `IMG_RESET;
      end else if (ce) begin
         if (state_r == ST_WR_A && step_ok) begin
            img_a_r <= grp_a;
         end
         if (state_r == ST_WR_B && step_ok) begin
            img_b_r <= {grp_c, grp_b};
         end
      end
   end

   // ==========================================================
   // remote I/O and serial images, refreshed at program end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rio_r <= '0;
         hex_r <= '0;
         ser_r <= '0;
      end else if (ce && prog_end) begin
         // upper byte is octal bits 10-17
         rio_r.word_a <= {out_a, 8'h00};
         rio_r.word_b <= {out_c, out_b};
         hex_r.byte_a <= out_a;
         hex_r.byte_b <= out_b;
         hex_r.byte_c <= out_c;
         ser_r.byte_a <= out_a;
         ser_r.byte_b_lo <= out_b;
         ser_r.byte_b_hi <= out_c;
      end
   end

   // ==========================================================
   // command bits from either port
   // backplane wins when both write in the same cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmd_r <= '0;
      end else if (ce) begin
         if (wr_cmd_bp) begin
            cmd_r[bp_cmd_lsb +: `CMD_WORD_W] <= bp_req.wdata;
         end else if (rio_cmd_we) begin
            cmd_r[rio_cmd_lsb +: `CMD_WORD_W] <= rio_cmd_data;
         end
      end
   end

   // ==========================================================
   // backplane read answer, one cycle after the request
   // the host must pick a quiet moment to read
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_r <= '0;
      end else if (ce) begin
         rsp_r.valid <= bp_req.rd;
         rsp_r.rdata <= bp_req.rd ? rd_word : 16'h0000;
      end
   end

   assign bp_rsp = rsp_r;
   assign rio_img = rio_r;
   assign hex_img = hex_r;
   assign ser_img = ser_r;
   assign cmd_bits = cmd_r;
   assign host_lock = lock_r;
   assign dev_busy = busy_r;

endmodule

/* verification/gage_lock_asserts.sv */
`timescale 1ns/1ps
// =====
// checker
module gage_lock_asserts (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   input wire gage_lock_pkg::bp_req_t bp_req,
   input wire gage_lock_pkg::bp_rsp_t bp_rsp,
   input wire logic prog_end,
   input wire gage_lock_pkg::rio_image_t rio_img,
   input wire gage_lock_pkg::hex_image_t hex_img,
   input wire gage_lock_pkg::ser_image_t ser_img,
   input wire logic host_lock,
   input wire logic dev_busy
);
   import gage_lock_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   rd_answer_a: assert property (ce && bp_req.rd |=> bp_rsp.valid)
      else $error("read not answered");
   stray_valid_a: assert property (bp_rsp.valid |-> $past(bp_req.rd))
      else $error("answer without read");
   idle_rdata_a: assert property (
      !bp_rsp.valid |-> bp_rsp.rdata == 16'h0000)
      else $error("read data not zero");
   lock_write_a: assert property (
      ce && bp_req.wr && bp_req.addr == 10'h000
      |=> host_lock == $past(bp_req.wdata[0]))
      else $error("lock bit not stored");
   start_gate_a: assert property ($rose(dev_busy) |-> !$past(host_lock))
      else $error("post started while locked");
   busy_min_a: assert property ($rose(dev_busy) |=> dev_busy)
      else $error("busy too short");
   busy_end_a: assert property ($rose(dev_busy) && !host_lock
      ##1 !host_lock |=> !dev_busy)
      else $error("busy not cleared");
   port_agree_a: assert property (
      hex_img == {rio_img.word_a[15:8], rio_img.word_b[7:0],
      rio_img.word_b[15:8]})
      else $error("hex and rio differ");
   byte_swap_a: assert property (ser_img == {hex_img.byte_a, hex_img.byte_c,
      hex_img.byte_b})
      else $error("byte swap wrong");
   img_hold_a: assert property (!$past(prog_end) |-> $stable(rio_img))
      else $error("image moved early");
   read_c: cover property (bp_rsp.valid);
   post_c: cover property ($rose(dev_busy));
   stall_c: cover property (dev_busy && host_lock);
endmodule
bind gage_flags_and_data_lock gage_lock_asserts u_gage_lock_asserts (
   .clk_sys(clk_sys), .srst(srst), .ce(ce), .bp_req(bp_req),
   .bp_rsp(bp_rsp), .prog_end(prog_end), .rio_img(rio_img),
   .hex_img(hex_img), .ser_img(ser_img), .host_lock(host_lock),
   .dev_busy(dev_busy));

/* verification/host_model.sv */
`timescale 1ns/1ps
// =====
// host on the shared-memory backplane
module host_model (
   input wire logic clk_sys,
   input wire gage_lock_pkg::bp_rsp_t bp_rsp,
   input wire logic dev_busy,
   input wire logic host_lock,
   output gage_lock_pkg::bp_req_t bp_req
);
   import gage_lock_pkg::*;
   initial bp_req = '0;
   // command words and lock go out as one-cycle writes
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bp_req <= '{1'b0, 1'b1, a, d};
      @(posedge clk_sys);
      bp_req <= '0;
   endtask
   task automatic rd(input logic [9:0] a, output logic [15:0] d,
         output bit ok);
      bit late;
      // a read mid-post could return half old, half new
      for (int n = 0; n < 40 && dev_busy && !host_lock; n++) begin
         @(posedge clk_sys);
      end
      // a busy still high after 40 cycles with the lock clear fails the read
      late = dev_busy && !host_lock;
      @(posedge clk_sys);
      bp_req <= '{1'b1, 1'b0, a, 16'h0000};
      @(posedge clk_sys);
      bp_req <= '0;
      @(posedge clk_sys);
      ok = (bp_rsp.valid === 1'b1) && !late;
      d = bp_rsp.rdata;
   endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import gage_lock_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic result_valid = 1'b0;
   logic prog_end = 1'b0;
   logic rio_cmd_we = 1'b0;
   logic [2:0] rio_cmd_idx = 3'h0;
   logic [15:0] rio_cmd_data = 16'h0000;
   gage_flags_t result_flags = '0;
   bp_req_t bp_req;
   bp_rsp_t bp_rsp;
   rio_image_t rio_img;
   hex_image_t hex_img;
   ser_image_t ser_img;
   logic [127:0] cmd_bits;
   logic host_lock;
   logic dev_busy;
   int fail_count = 0;
   int checked = 0;
   int m_cmd[8];
   logic [31:0] m_img = '0;
   logic [31:0] r;
   logic [31:0] prev;
   always #2.5 clk_sys = ~clk_sys;
   gage_flags_and_data_lock u_gage_flags_and_data_lock (.clk_sys(clk_sys),
      .srst(srst), .ce(ce), .bp_req(bp_req), .bp_rsp(bp_rsp),
      .result_valid(result_valid), .result_flags(result_flags),
      .prog_end(prog_end), .rio_cmd_we(rio_cmd_we),
      .rio_cmd_idx(rio_cmd_idx), .rio_cmd_data(rio_cmd_data),
      .rio_img(rio_img), .hex_img(hex_img), .ser_img(ser_img),
      .cmd_bits(cmd_bits), .host_lock(host_lock), .dev_busy(dev_busy));
   host_model u_host_model (.clk_sys(clk_sys), .bp_rsp(bp_rsp),
      .dev_busy(dev_busy), .host_lock(host_lock), .bp_req(bp_req));
   // =====
   // compare and closing
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_i(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // =====
   // model and helpers
   task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
      logic [15:0] d;
      bit ok;
      u_host_model.rd(a, d, ok);
      chk_w({15'h0000, ok}, 16'h0001);
      chk_w(d, exp);
   endtask
   task automatic wait_busy(input logic v);
      for (int n = 0; n < 30 && dev_busy !== v; n++) begin
         @(posedge clk_sys);
      end
      if (dev_busy !== v) begin
         chk_w({15'h0000, dev_busy}, {15'h0000, v});
         stop_test();
      end
   endtask
   // warning on the even bit, fault on the odd one, gage 53 at bit 8
   task automatic post(input logic pe);
      r = $urandom;
      for (int g = 0; g < 12; g++) begin
         m_img[8 + 2 * g] = r[g];
         m_img[9 + 2 * g] = r[12 + g];
      end
      @(posedge clk_sys);
      result_flags <= r[23:0];
      result_valid <= 1'b1;
      prog_end <= pe;
      @(posedge clk_sys);
      result_valid <= 1'b0;
      prog_end <= 1'b0;
   endtask
   // =====
   // main sequence
   initial begin
      void'($urandom(31));
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      rd_chk(10'h000, 16'h0000);
      rd_chk(10'h01E, 16'h0000);
      rd_chk(10'h100, 16'h0000);
      $display("test reset done");
      repeat (4) begin
         post(1'b1);
         wait_busy(1'b1);
         wait_busy(1'b0);
         rd_chk(10'h01E, m_img[15:0]);
         rd_chk(10'h01F, m_img[31:16]);
         chk_i(rio_img, {m_img[15:0], m_img[31:16]});
         chk_i({8'h00, hex_img},
            {8'h00, m_img[15:8], m_img[23:16], m_img[31:24]});
         chk_i({8'h00, ser_img}, {8'h00, m_img[15:8], m_img[31:16]});
      end
      u_host_model.wr(10'h01E, 16'hFFFF);
      rd_chk(10'h01E, m_img[15:0]);
      $display("test results done");
      u_host_model.wr(10'h000, 16'hFFFF);
      rd_chk(10'h000, 16'h0001);
      prev = m_img;
      post(1'b0);
      repeat (6) @(posedge clk_sys);
      chk_w({15'h0000, dev_busy}, 16'h0000);
      rd_chk(10'h01F, prev[31:16]);
      u_host_model.wr(10'h000, 16'h0000);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd_chk(10'h01F, m_img[31:16]);
      $display("test lock done");
      for (int k = 0; k < 8; k++) begin
         r = $urandom;
         m_cmd[k] = r[15:0];
         u_host_model.wr(10'(k + 2), r[15:0]);
         rd_chk(10'(k + 2), 16'(m_cmd[k]));
         m_cmd[k] = r[31:16];
         @(posedge clk_sys);
         rio_cmd_we <= 1'b1;
         rio_cmd_idx <= 3'(k);
         rio_cmd_data <= r[31:16];
         @(posedge clk_sys);
         rio_cmd_we <= 1'b0;
         @(posedge clk_sys);
         chk_w(cmd_bits[16 * k +: 16], 16'(m_cmd[k]));
         rd_chk(10'(k + 2), 16'(m_cmd[k]));
      end
      $display("test commands done");
      // a command write with the enable low must be lost
      @(posedge clk_sys);
      ce <= 1'b0;
      rio_cmd_we <= 1'b1;
      rio_cmd_idx <= 3'h0;
      rio_cmd_data <= ~r[31:16];
      @(posedge clk_sys);
      rio_cmd_we <= 1'b0;
      ce <= 1'b1;
      @(posedge clk_sys);
      chk_w(cmd_bits[15:0], 16'(m_cmd[0]));
      rd_chk(10'h002, 16'(m_cmd[0]));
      $display("test enable done");
      stop_test();
   end
endmodule
